//--- hdl/ccr_pkg.sv
// Package of constants and types for the channel calibration register bank
package ccr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [5:0] CCR_CHAN2_OFFSET_UPPER = 6'h14;
    localparam logic [5:0] CCR_CHAN2_OFFSET_LOWER = 6'h15;
    localparam logic [5:0] CCR_CHAN2_GAIN_UPPER   = 6'h16;
    localparam logic [5:0] CCR_CHAN2_GAIN_LOWER   = 6'h17;
    localparam logic [5:0] CCR_CHAN3_CONFIG       = 6'h18;
    localparam logic [5:0] CCR_CHAN3_OFFSET_UPPER = 6'h19;
    localparam logic [5:0] CCR_CHAN3_OFFSET_LOWER = 6'h1A;
    localparam logic [5:0] CCR_CHAN3_GAIN_UPPER   = 6'h1B;
    localparam logic [5:0] CCR_CHAN3_GAIN_LOWER   = 6'h1C;
    localparam logic [5:0] CCR_MAP_CHECKSUM       = 6'h3E;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CCR_LOW_FIELD_MSB   = 15;
    localparam int CCR_LOW_FIELD_LSB   = 8;
    localparam int CCR_PHASE_MSB       = 15;
    localparam int CCR_PHASE_LSB       = 6;
    localparam int CCR_HP_OVERRIDE_BIT = 2;
    localparam int CCR_MUX_MSB         = 1;
    localparam int CCR_MUX_LSB         = 0;
    localparam int CCR_GAIN_FRAC_BITS  = 23;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] CCR_OFFSET_UPPER_RST = 16'h0000;
    localparam logic [7:0]  CCR_LOW_FIELD_RST    = 8'h00;
    localparam logic [15:0] CCR_GAIN_UPPER_RST   = 16'h8000;
    localparam logic [9:0]  CCR_PHASE_RST        = 10'h000;
    localparam logic        CCR_HP_OVERRIDE_RST  = 1'b0;
    localparam logic [15:0] CCR_READ_ZERO        = 16'h0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CCR_MUX_EXTERNAL  = 2'b00,
        CCR_MUX_SHORTED   = 2'b01,
        CCR_MUX_DIAG_POS  = 2'b10,
        CCR_MUX_DIAG_NEG  = 2'b11
    } ccr_mux_type;

    typedef struct packed {
        logic [15:0] offset_high;
        logic [7:0]  offset_low;
        logic [15:0] gain_high;
        logic [7:0]  gain_low;
    } ccr_cal_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } ccr_req_type;

    typedef struct packed {
        logic        valid;
        logic [23:0] data;
    } ccr_sample_type;

    typedef struct packed {
        ccr_cal_type  chan2;
        ccr_cal_type  chan3;
        logic [9:0]   chan3_phase_delay;
        logic         chan3_highpass_override;
        ccr_mux_type  chan3_input_select;
        logic [15:0]  rdata;
        logic         rvalid;
    } ccr_state_type;

endpackage

//--- hdl/ccr_cal_apply.sv
// Per-channel offset and gain correction of one sample stream
`timescale 1ns/1ps
module ccr_cal_apply (
    // Clock and reset
    input  wire logic                    sys_clk_i,
    input  wire logic                    reset_n_i,
    // Calibration words
    input  wire logic [23:0]             offset_i,
    input  wire logic [23:0]             gain_i,
    // Samples
    input  wire ccr_pkg::ccr_sample_type sample_i,
    output ccr_pkg::ccr_sample_type      sample_o
);

    ccr_pkg::ccr_sample_type state_q;
    ccr_pkg::ccr_sample_type state_d;

    logic signed [24:0] diff;
    logic signed [50:0] product;
    logic signed [27:0] scaled;

    // ------------------------------------------------------------------
    // Correction: (sample - offset) * gain, gain 800000h is unity
    // ------------------------------------------------------------------
    always_comb begin
        diff    = 25'($signed(sample_i.data)) - 25'($signed(offset_i));
        product = 51'(diff) * $signed({27'h0000000, gain_i});
        scaled  = 28'(product >>> ccr_pkg::CCR_GAIN_FRAC_BITS);
        state_d = state_q;
        state_d.valid = sample_i.valid;
        if (sample_i.valid) begin
            // Saturate rather than wrap, a wrapped sample is a full-scale glitch
            if (scaled > 28'sh07FFFFF) begin
                state_d.data = 24'h7FFFFF;
            end else if (scaled < -28'sh0800000) begin
                state_d.data = 24'h800000;
            end else begin
                state_d.data = scaled[23:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sample_o = state_q;

    a_unity_passthrough: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (sample_i.valid && offset_i == 24'h000000 && gain_i == 24'h800000)
        |=> (sample_o.valid && sample_o.data == $past(sample_i.data)))
        else $error("unity calibration did not pass the sample through");

endmodule // ccr_cal_apply

//--- hdl/ccr_regs.sv
// Calibration and configuration register bank for channels 2 and 3
// ------------------------------------------------------------------
// Functional notes
// - Offset bits 23:8 sit in the 16-bit upper offset register, read/write, reset zero.
// - Offset bits 7:0 sit in lower register bits 15:8; low byte reads zero.
// - Gain bits 23:8 sit in the upper gain register, reset 8000h for unity.
// - Gain bits 7:0 sit in lower register bits 15:8, reset zero; low byte zero.
// - Channel 3 phase delay is config bits 15:6, reset zero; bits 5:3 read-only.
// - Config bit 2 set disables channel 3 highpass; clear follows global setting.
// - Config bits 1:0 pick channel 3 input: pins, shorted, positive or negative diag.
// ------------------------------------------------------------------
`timescale 1ns/1ps
module ccr_regs (
    // Clock and reset
    input  wire logic                    sys_clk_i,
    input  wire logic                    reset_n_i,
    // Register port from the serial interface
    input  wire ccr_pkg::ccr_req_type    req_i,
    input  wire logic [15:0]             map_checksum_i,
    output logic [15:0]                  rdata_o,
    output logic                         rvalid_o,
    // Sample streams
    input  wire ccr_pkg::ccr_sample_type chan2_sample_i,
    input  wire ccr_pkg::ccr_sample_type chan3_sample_i,
    output ccr_pkg::ccr_sample_type      chan2_sample_o,
    output ccr_pkg::ccr_sample_type      chan3_sample_o,
    // Channel 3 front end control
    input  wire logic                    global_highpass_setting_i,
    output logic                         chan3_highpass_enable_o,
    output logic [9:0]                   chan3_phase_delay_o,
    output ccr_pkg::ccr_mux_type         chan3_input_select_o,
    output logic                         chan3_pos_input_o,
    output logic                         chan3_neg_input_o,
    output logic                         chan3_inputs_shorted_o,
    output logic                         chan3_diag_pos_o,
    output logic                         chan3_diag_neg_o
);

    ccr_pkg::ccr_state_type state_q;
    ccr_pkg::ccr_state_type state_d;

    logic [23:0] chan2_offset;
    logic [23:0] chan2_gain;
    logic [23:0] chan3_offset;
    logic [23:0] chan3_gain;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Joins an upper register and a stored low field into one 24-bit word
    function automatic logic [23:0] join_word(input logic [15:0] high,
                                              input logic [7:0] low);
        join_word = {high, low};
    endfunction

    // Places a stored low field in bits 15:8, reserved low byte reads zero
    function automatic logic [15:0] low_view(input logic [7:0] low);
        low_view = {low, 8'h00};
    endfunction

    // Readback of the channel 3 configuration register
    function automatic logic [15:0] config_view(input ccr_pkg::ccr_state_type s);
        config_view = {s.chan3_phase_delay, 3'b000, s.chan3_highpass_override,
                       s.chan3_input_select};
    endfunction

    // ------------------------------------------------------------------
    // Register writes and reads
    // ------------------------------------------------------------------
    always_comb begin
        state_d        = state_q;
        state_d.rvalid = req_i.rd;
        if (req_i.wr) begin
            unique case (req_i.addr)
                ccr_pkg::CCR_CHAN2_OFFSET_UPPER: begin
                    state_d.chan2.offset_high = req_i.wdata;
                end
                ccr_pkg::CCR_CHAN2_OFFSET_LOWER: begin
                    state_d.chan2.offset_low = req_i.wdata[15:8];
                end
                ccr_pkg::CCR_CHAN2_GAIN_UPPER: begin
                    state_d.chan2.gain_high = req_i.wdata;
                end
                ccr_pkg::CCR_CHAN2_GAIN_LOWER: begin
                    state_d.chan2.gain_low = req_i.wdata[15:8];
                end
                ccr_pkg::CCR_CHAN3_CONFIG: begin
                    state_d.chan3_phase_delay =
                        req_i.wdata[ccr_pkg::CCR_PHASE_MSB:ccr_pkg::CCR_PHASE_LSB];
                    state_d.chan3_highpass_override =
                        req_i.wdata[ccr_pkg::CCR_HP_OVERRIDE_BIT];
                    state_d.chan3_input_select = ccr_pkg::ccr_mux_type'(
                        req_i.wdata[ccr_pkg::CCR_MUX_MSB:ccr_pkg::CCR_MUX_LSB]);
                end
                ccr_pkg::CCR_CHAN3_OFFSET_UPPER: begin
                    state_d.chan3.offset_high = req_i.wdata;
                end
                ccr_pkg::CCR_CHAN3_OFFSET_LOWER: begin
                    state_d.chan3.offset_low = req_i.wdata[15:8];
                end
                ccr_pkg::CCR_CHAN3_GAIN_UPPER: begin
                    state_d.chan3.gain_high = req_i.wdata;
                end
                ccr_pkg::CCR_CHAN3_GAIN_LOWER: begin
                    state_d.chan3.gain_low = req_i.wdata[15:8];
                end
                // Read-only checksum and unmapped offsets ignore writes
                default: begin
                end
            endcase
        end
        // A read in the same cycle as a write returns the old contents
        if (req_i.rd) begin
            unique case (req_i.addr)
                ccr_pkg::CCR_CHAN2_OFFSET_UPPER: begin
                    state_d.rdata = state_q.chan2.offset_high;
                end
                ccr_pkg::CCR_CHAN2_OFFSET_LOWER: begin
                    state_d.rdata = low_view(state_q.chan2.offset_low);
                end
                ccr_pkg::CCR_CHAN2_GAIN_UPPER: begin
                    state_d.rdata = state_q.chan2.gain_high;
                end
                ccr_pkg::CCR_CHAN2_GAIN_LOWER: begin
                    state_d.rdata = low_view(state_q.chan2.gain_low);
                end
                ccr_pkg::CCR_CHAN3_CONFIG: begin
                    state_d.rdata = config_view(state_q);
                end
                ccr_pkg::CCR_CHAN3_OFFSET_UPPER: begin
                    state_d.rdata = state_q.chan3.offset_high;
                end
                ccr_pkg::CCR_CHAN3_OFFSET_LOWER: begin
                    state_d.rdata = low_view(state_q.chan3.offset_low);
                end
                ccr_pkg::CCR_CHAN3_GAIN_UPPER: begin
                    state_d.rdata = state_q.chan3.gain_high;
                end
                ccr_pkg::CCR_CHAN3_GAIN_LOWER: begin
                    state_d.rdata = low_view(state_q.chan3.gain_low);
                end
                ccr_pkg::CCR_MAP_CHECKSUM: begin
                    state_d.rdata = map_checksum_i;
                end
                default: begin
                    state_d.rdata = ccr_pkg::CCR_READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            state_q.chan2.offset_high       <= ccr_pkg::CCR_OFFSET_UPPER_RST;
            state_q.chan2.offset_low        <= ccr_pkg::CCR_LOW_FIELD_RST;
            state_q.chan2.gain_high         <= ccr_pkg::CCR_GAIN_UPPER_RST;
            state_q.chan2.gain_low          <= ccr_pkg::CCR_LOW_FIELD_RST;
            state_q.chan3.offset_high       <= ccr_pkg::CCR_OFFSET_UPPER_RST;
            state_q.chan3.offset_low        <= ccr_pkg::CCR_LOW_FIELD_RST;
            state_q.chan3.gain_high         <= ccr_pkg::CCR_GAIN_UPPER_RST;
            state_q.chan3.gain_low          <= ccr_pkg::CCR_LOW_FIELD_RST;
            state_q.chan3_phase_delay       <= ccr_pkg::CCR_PHASE_RST;
            state_q.chan3_highpass_override <= ccr_pkg::CCR_HP_OVERRIDE_RST;
            state_q.chan3_input_select      <= ccr_pkg::CCR_MUX_EXTERNAL;
            state_q.rdata                   <= ccr_pkg::CCR_READ_ZERO;
            state_q.rvalid                  <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Effective calibration words and correction
    // ------------------------------------------------------------------
    assign chan2_offset = join_word(state_q.chan2.offset_high, state_q.chan2.offset_low);
    assign chan2_gain   = join_word(state_q.chan2.gain_high, state_q.chan2.gain_low);
    assign chan3_offset = join_word(state_q.chan3.offset_high, state_q.chan3.offset_low);
    assign chan3_gain   = join_word(state_q.chan3.gain_high, state_q.chan3.gain_low);

    ccr_cal_apply u_chan2_cal (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .offset_i  (chan2_offset),
        .gain_i    (chan2_gain),
        .sample_i  (chan2_sample_i),
        .sample_o  (chan2_sample_o)
    );

    ccr_cal_apply u_chan3_cal (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .offset_i  (chan3_offset),
        .gain_i    (chan3_gain),
        .sample_i  (chan3_sample_i),
        .sample_o  (chan3_sample_o)
    );

    // ------------------------------------------------------------------
    // Channel 3 front end
    // ------------------------------------------------------------------
    // Override only ever disables; it cannot enable a globally disabled filter
    assign chan3_highpass_enable_o = global_highpass_setting_i
                                     && !state_q.chan3_highpass_override;
    assign chan3_phase_delay_o     = state_q.chan3_phase_delay;
    assign chan3_input_select_o    = state_q.chan3_input_select;

    always_comb begin
        chan3_pos_input_o      = 1'b0;
        chan3_neg_input_o      = 1'b0;
        chan3_inputs_shorted_o = 1'b0;
        chan3_diag_pos_o       = 1'b0;
        chan3_diag_neg_o       = 1'b0;
        unique case (state_q.chan3_input_select)
            ccr_pkg::CCR_MUX_EXTERNAL: begin
                chan3_pos_input_o = 1'b1;
                chan3_neg_input_o = 1'b1;
            end
            ccr_pkg::CCR_MUX_SHORTED: begin
                chan3_inputs_shorted_o = 1'b1;
            end
            ccr_pkg::CCR_MUX_DIAG_POS: begin
                chan3_diag_pos_o = 1'b1;
            end
            ccr_pkg::CCR_MUX_DIAG_NEG: begin
                chan3_diag_neg_o = 1'b1;
            end
        endcase
    end

    assign rdata_o  = state_q.rdata;
    assign rvalid_o = state_q.rvalid;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_write_at(logic [5:0] a);
        req_i.wr && !req_i.rd && req_i.addr == a;
    endsequence

    sequence s_read_at(logic [5:0] a);
        req_i.rd && !req_i.wr && req_i.addr == a;
    endsequence

    a_offset_upper_rw: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_write_at(ccr_pkg::CCR_CHAN2_OFFSET_UPPER) ##2 s_read_at(ccr_pkg::CCR_CHAN2_OFFSET_UPPER)
        |=> rvalid_o && rdata_o == $past(req_i.wdata, 3))
        else $error("upper offset readback differs from written value");

    a_offset_low_byte: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_write_at(ccr_pkg::CCR_CHAN3_OFFSET_LOWER) ##2 s_read_at(ccr_pkg::CCR_CHAN3_OFFSET_LOWER)
        |=> rdata_o == {$past(req_i.wdata[15:8], 3), 8'h00})
        else $error("lower offset readback wrong or low byte not zero");

    a_gain_unity_reset: assert property (@(posedge sys_clk_i)
        !reset_n_i |=> state_q.chan2.gain_high == 16'h8000 && state_q.chan3.gain_high == 16'h8000
                       && chan2_gain == 24'h800000)
        else $error("gain upper register not at unity after reset");

    a_gain_low_byte: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_read_at(ccr_pkg::CCR_CHAN2_GAIN_LOWER) |=> rdata_o[7:0] == 8'h00
        && rdata_o[15:8] == $past(state_q.chan2.gain_low))
        else $error("lower gain readback wrong");

    a_config_reserved: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_write_at(ccr_pkg::CCR_CHAN3_CONFIG) ##2 s_read_at(ccr_pkg::CCR_CHAN3_CONFIG)
        |=> rdata_o == ($past(req_i.wdata, 3) & 16'hFFC7)
        && chan3_phase_delay_o == $past(req_i.wdata[15:6], 3))
        else $error("config readback or phase delay wrong");

    a_highpass_override: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_write_at(ccr_pkg::CCR_CHAN3_CONFIG) |=> chan3_highpass_enable_o
        == (global_highpass_setting_i && !$past(req_i.wdata[ccr_pkg::CCR_HP_OVERRIDE_BIT])))
        else $error("highpass enable does not follow override and global setting");

    a_input_select: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_write_at(ccr_pkg::CCR_CHAN3_CONFIG) |=> chan3_input_select_o == $past(req_i.wdata[1:0])
        && $onehot({chan3_pos_input_o, chan3_inputs_shorted_o, chan3_diag_pos_o, chan3_diag_neg_o})
        && chan3_diag_neg_o == ($past(req_i.wdata[1:0]) == 2'b11))
        else $error("input select did not follow configuration write");

    a_word_join: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_write_at(ccr_pkg::CCR_CHAN3_GAIN_LOWER) |=> chan3_gain[7:0] == $past(req_i.wdata[15:8])
        && chan3_gain[23:8] == $past(state_q.chan3.gain_high))
        else $error("effective gain word not joined from upper and lower");

    a_unmapped_zero: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_read_at(6'h3F) |=> rvalid_o && rdata_o == 16'h0000)
        else $error("unmapped read did not return zero");

    a_read_answer: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        1'b1 |=> rvalid_o == $past(req_i.rd))
        else $error("read answer strobe not exactly one cycle after the read");

    a_checksum_read: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_read_at(ccr_pkg::CCR_MAP_CHECKSUM) |=> rdata_o == $past(map_checksum_i))
        else $error("checksum read did not return the checksum input");

    a_gain_upper_rw: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_write_at(ccr_pkg::CCR_CHAN3_GAIN_UPPER) |=> chan3_gain[23:8] == $past(req_i.wdata))
        else $error("upper gain write did not reach the effective word");

    a_select_reset: assert property (@(posedge sys_clk_i)
        !reset_n_i |=> chan3_input_select_o == ccr_pkg::CCR_MUX_EXTERNAL
        && chan3_pos_input_o && chan3_neg_input_o && chan3_phase_delay_o == 10'h000)
        else $error("channel 3 front end not at default after reset");

endmodule // ccr_regs

//--- test/ccr_host_model.sv
// Host model issuing word-level register reads and writes
`timescale 1ns/1ps
module ccr_host_model (
    // Clock
    input  wire logic            sys_clk_i,
    // Register port
    output ccr_pkg::ccr_req_type req_o,
    input  wire logic [15:0]     rdata_i,
    input  wire logic            rvalid_i
);
    initial req_o = '0;
    // Released lines show the inverse so a stale value is never mistaken for a fresh one
    task automatic write_reg(input logic [5:0] addr, input logic [15:0] data);
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'h1, rd: 1'h0, addr: addr, wdata: data};
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'h0, rd: 1'h0, addr: ~addr, wdata: ~data};
    endtask
    task automatic read_reg(input logic [5:0] addr, output logic [15:0] data, output logic ok);
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'h0, rd: 1'h1, addr: addr, wdata: 16'h0000};
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'h0, rd: 1'h0, addr: ~addr, wdata: 16'hFFFF};
        #1;
        ok = rvalid_i;
        data = rdata_i;
    endtask
endmodule // ccr_host_model

//--- test/tb_top.sv
// Self-checking testbench for the channel calibration register bank
`timescale 1ns/1ps
module tb_top;
    logic                    sys_clk_i = 1'h0;
    logic                    reset_n_i = 1'h0;
    ccr_pkg::ccr_req_type    req;
    logic [15:0]             map_checksum = 16'hA5C3;
    logic [15:0]             rdata;
    logic                    rvalid;
    ccr_pkg::ccr_sample_type s2_in = '0;
    ccr_pkg::ccr_sample_type s3_in = '0;
    ccr_pkg::ccr_sample_type s2_out;
    ccr_pkg::ccr_sample_type s3_out;
    logic                    global_hp = 1'h1;
    logic                    hp_en;
    logic [9:0]              phase;
    ccr_pkg::ccr_mux_type    sel;
    logic [4:0]              lines;
    logic [15:0]             rd_word;
    logic                    rd_ok;
    int                      n_errors = 0;
    int                      cmp_count = 0;
    localparam logic [5:0]  addr_tab [10] = '{6'h14, 6'h15, 6'h16, 6'h17, 6'h18,
                                             6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h3E};
    localparam logic [15:0] rst_tab [10] = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000,
                                            16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'hA5C3};
    // Read-back after writing all ones: reserved bits stay zero, checksum untouched
    localparam logic [15:0] ones_tab [10] = '{16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7,
                                             16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hA5C3};
    localparam logic [4:0]  lines_tab [4] = '{5'h18, 5'h04, 5'h02, 5'h01};

    always #20 sys_clk_i = ~sys_clk_i;

    ccr_regs i_ccr_regs (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .req_i(req),
        .map_checksum_i(map_checksum), .rdata_o(rdata), .rvalid_o(rvalid),
        .chan2_sample_i(s2_in), .chan3_sample_i(s3_in),
        .chan2_sample_o(s2_out), .chan3_sample_o(s3_out),
        .global_highpass_setting_i(global_hp), .chan3_highpass_enable_o(hp_en),
        .chan3_phase_delay_o(phase), .chan3_input_select_o(sel),
        .chan3_pos_input_o(lines[4]), .chan3_neg_input_o(lines[3]),
        .chan3_inputs_shorted_o(lines[2]), .chan3_diag_pos_o(lines[1]),
        .chan3_diag_neg_o(lines[0])
    );
    ccr_host_model i_ccr_host_model (
        .sys_clk_i(sys_clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid)
    );

    // ------------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------------
    task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_reg(input logic [5:0] addr, input logic [15:0] exp);
        i_ccr_host_model.read_reg(addr, rd_word, rd_ok);
        cmp_val({7'h00, rd_ok, rd_word}, {7'h00, 1'h1, exp});
    endtask
    task automatic test_done();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Signed correction with saturation, worked out independently of the design
    function automatic logic [23:0] corr(input logic [23:0] x, input logic [23:0] off,
                                         input logic [23:0] g);
        longint p;
        p = ((longint'($signed(x)) - longint'($signed(off))) * longint'(g)) >>> 23;
        if (p > 64'sh7FFFFF) p = 64'sh7FFFFF;
        if (p < -64'sh800000) p = -64'sh800000;
        return p[23:0];
    endfunction

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // One valid pulse on both channels, channel 3 gets the inverse; returns when outputs settle
    task automatic drive_samples(input logic [23:0] x);
        @(posedge sys_clk_i);
        s2_in <= '{valid: 1'h1, data: x};
        s3_in <= '{valid: 1'h1, data: ~x};
        @(posedge sys_clk_i);
        s2_in <= '{valid: 1'h0, data: ~x};
        s3_in <= '{valid: 1'h0, data: x};
        #1;
    endtask
    task automatic check_reset_values();
        for (int i = 0; i < 10; i++) cmp_reg(addr_tab[i], rst_tab[i]);
        cmp_reg(6'h3F, 16'h0000);
        drive_samples(24'h123456);
        cmp_val(s2_out.data, corr(24'h123456, 24'h000000, 24'h800000));
        cmp_val(s3_out.data, corr(24'hEDCBA9, 24'h000000, 24'h800000));
    endtask
    task automatic check_write_then_read();
        i_ccr_host_model.write_reg(6'h14, 16'h1234);
        cmp_reg(6'h14, 16'h1234);
        i_ccr_host_model.write_reg(6'h1A, 16'h5AA5);
        cmp_reg(6'h1A, 16'h5A00);
        i_ccr_host_model.write_reg(6'h18, 16'hABCD);
        cmp_reg(6'h18, 16'hABC5);
    endtask
    task automatic check_write_all_ones();
        for (int i = 0; i < 10; i++) i_ccr_host_model.write_reg(addr_tab[i], 16'hFFFF);
        i_ccr_host_model.write_reg(6'h20, 16'hFFFF);
        for (int i = 0; i < 10; i++) cmp_reg(addr_tab[i], ones_tab[i]);
        cmp_reg(6'h20, 16'h0000);
    endtask
    task automatic check_config_outputs();
        for (int m = 0; m < 4; m++) begin
            for (int ov = 0; ov < 2; ov++) begin
                global_hp <= m[0];
                i_ccr_host_model.write_reg(6'h18, {10'h155, 3'h7, ov[0], m[1:0]});
                #1;
                cmp_val({14'h0000, phase}, {14'h0000, 10'h155});
                cmp_val({23'h000000, hp_en}, {23'h000000, m[0] & ~ov[0]});
                cmp_val({22'h000000, sel}, {22'h000000, m[1:0]});
                cmp_val({19'h00000, lines}, {19'h00000, lines_tab[m]});
            end
        end
    endtask
    task automatic check_correction();
        logic [23:0] x;
        i_ccr_host_model.write_reg(6'h14, 16'h0001);
        i_ccr_host_model.write_reg(6'h15, 16'h03FF);
        i_ccr_host_model.write_reg(6'h16, 16'h4000);
        i_ccr_host_model.write_reg(6'h17, 16'h80FF);
        i_ccr_host_model.write_reg(6'h19, 16'hFFFF);
        i_ccr_host_model.write_reg(6'h1A, 16'hFF00);
        i_ccr_host_model.write_reg(6'h1B, 16'hFFFF);
        i_ccr_host_model.write_reg(6'h1C, 16'hFF00);
        for (int i = 0; i < 4; i++) begin
            x = (i == 0) ? 24'h000500 : (i == 1) ? 24'h800000 : (i == 2) ? 24'h7FFFF0 : 24'hFFF000;
            drive_samples(x);
            cmp_val({23'h000000, s2_out.valid & s3_out.valid}, 24'h000001);
            cmp_val(s2_out.data, corr(x, 24'h000103, 24'h400080));
            cmp_val(s3_out.data, corr(~x, 24'hFFFFFF, 24'hFFFFFF));
        end
    endtask

    initial begin
        repeat (20) @(posedge sys_clk_i);
        reset_n_i <= 1'h1;
        check_reset_values();
        check_write_all_ones();
        check_write_then_read();
        check_config_outputs();
        check_correction();
        test_done();
    end
    // Whole run needs well under 1000 cycles; this bounds a hung handshake
    initial begin
        #400000;
        n_errors++;
        test_done();
    end
endmodule // tb_top
